// File: design/fspc_pkg.sv
// Shared constants and types for the flash self-program controller
package fspc_pkg;

    // Register byte offsets on APB
    localparam logic [11:0] OFS_CTRL_STATUS  = 12'h000;
    localparam logic [11:0] OFS_POINTER_LOW  = 12'h004;
    localparam logic [11:0] OFS_POINTER_HIGH = 12'h008;

    // Control/status field positions
    localparam int BIT_IRQ_EN   = 7;
    localparam int BIT_BUSY     = 6;
    localparam int BIT_RESERVED = 5;
    localparam int BIT_REENABLE = 4;
    localparam int BIT_LOCK_SET = 3;
    localparam int BIT_PG_WRITE = 2;
    localparam int BIT_PG_ERASE = 1;
    localparam int BIT_ENABLE   = 0;

    // Reset values
    localparam logic [7:0]  CTRL_RESET    = 8'h00;
    localparam logic [15:0] POINTER_RESET = 16'h0000;
    localparam logic [7:0]  LOCK_RESET    = 8'hFF;
    localparam logic [15:0] APP_VECTOR    = 16'h0000;

    // Accepted command patterns in the low five bits
    localparam logic [4:0] CMD_REENABLE = 5'h11;
    localparam logic [4:0] CMD_LOCK_SET = 5'h09;
    localparam logic [4:0] CMD_PG_WRITE = 5'h05;
    localparam logic [4:0] CMD_PG_ERASE = 5'h03;
    localparam logic [4:0] CMD_LOAD     = 5'h01;

    // Only lock bits 5..2 can be programmed from software
    localparam logic [7:0] LOCK_KEEP_MASK = 8'hC3;

    // Fuse/lock read selectors (pointer low bits)
    localparam logic [1:0] SEL_FUSE_LOW  = 2'h0;
    localparam logic [1:0] SEL_LOCK      = 2'h1;
    localparam logic [1:0] SEL_FUSE_EXT  = 2'h2;
    localparam logic [1:0] SEL_FUSE_HIGH = 2'h3;

    // Arming windows in CPU cycles
    localparam logic [2:0] STORE_WINDOW = 3'h4;
    localparam logic [2:0] LOAD_WINDOW  = 3'h3;

    // Timing
    localparam int CLK_PERIOD_NS    = 100;
    localparam int PROG_TIME_US     = 4000;
    localparam int PROG_CYCLES_DEF  = PROG_TIME_US * 1000 / CLK_PERIOD_NS;

    // Control/status register layout
    typedef struct packed {
        logic irq_en;
        logic busy;
        logic reserved;
        logic reenable;
        logic lock_set;
        logic pg_write;
        logic pg_erase;
        logic enable;
    } fspc_ctrl_t;

    // Store/load request from the CPU core
    typedef struct packed {
        logic        store;
        logic        load;
        logic [15:0] data_pair;
    } fspc_cpu_req_t;

    typedef enum logic [1:0] {
        OP_IDLE,
        OP_ERASE,
        OP_WRITE
    } fspc_op_t;

endpackage : fspc_pkg

// File: design/fspc_top.sv
// Flash self-program controller with APB register access
//
// Overview of operation
// RULE1 - Reset vector is 0x0000 when boot fuse is 1, boot start when 0.
// RULE2 - Fuses are inputs only; the processor has no path to alter them.
// RULE3 - Control register resets to zero; bit 5 ignores writes and reads zero.
// RULE4 - Ready interrupt requested while irq enable, global enable set, enable bit clear.
// RULE5 - Erase or write to concurrent section sets busy flag, blocking its reads; flash_read is still issued while busy.
// RULE6 - Busy clears on re-enable store after programming, or on word load.
// RULE7 - Re-enable plus enable arms four cycles; ignored while erase/write runs.
// RULE8 - Writing re-enable during buffer loading discards all loaded buffer data.
// RULE9 - Lock-set store within four cycles programs lock bits from low data byte.
// RULE10 - Load within three cycles of lock-set returns lock or fuse bits.
// RULE11 - Page-write store within four cycles writes buffer to pointer's page.
// RULE12 - Page-erase store within four cycles erases the pointer's page.
// RULE13 - Erase or write to the blocking section halts the CPU throughout.
// RULE14 - Enable alone arms a buffer word load of the data pair at pointer word.
// RULE15 - Enable self-clears after store or window; held through erase and write.
// RULE16 - Only the five listed low-bit command patterns take effect.
// RULE17 - Low pointer bits pick the word, high bits pick the page.
// RULE18 - Target page is latched at operation start.
// RULE19 - Loads address flash bytes, pointer bit 0 selecting low or high byte.
// RULE20 - Software erases a page before writing it.
// RULE21 - Buffer words may be loaded in any order.
// RULE22 - Software gives erase and write the same page address.
// RULE23 - Buffer clears after page write, re-enable and reset; one load per word.
// RULE24 - EEPROM write in progress blocks commands and fuse/lock reads.
// RULE25 - Pointer 1 lock, 0 low fuse, 3 high fuse, 2 extended fuse.
// RULE26 - Returned fuse and lock bits read zero programmed, one unprogrammed.
// RULE27 - Arming window counts from the cycle after the write, then clears commands.
// RULE28 - Erase and write duration is a module parameter.
//
// Implementation choices: the address map and the APB interface to the registers.
`timescale 1ns/100ps

module fspc_top #(
    parameter int          PAGE_WORD_BITS   = 5,
    parameter int          PROG_CYCLES      = fspc_pkg::PROG_CYCLES_DEF,
    parameter logic [15:0] BOOT_START       = 16'h1C00,
    parameter logic [9:0]  BLOCK_FIRST_PAGE = 10'h380
) (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [11:0]           paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire fspc_pkg::fspc_cpu_req_t cpu_req,
    input  wire logic                  global_irq_enable,
    input  wire logic                  eeprom_write_active,
    input  wire logic                  boot_reset_select,
    input  wire logic [7:0]            fuse_low,
    input  wire logic [7:0]            fuse_high,
    input  wire logic [7:0]            fuse_ext,
    output logic      [15:0]           reset_vector,
    output logic                       ready_irq,
    output logic                       cpu_halt,
    output logic                       concurrent_busy,
    output logic      [7:0]            load_data,
    output logic                       load_data_valid,
    output logic                       flash_read,
    output logic      [15:0]           flash_read_addr,
    output logic                       prog_erase,
    output logic                       prog_write,
    output logic      [14-PAGE_WORD_BITS:0] prog_page,
    output logic                       prog_wvalid,
    output logic      [PAGE_WORD_BITS-1:0]  prog_wword,
    output logic      [15:0]           prog_wdata
);

    localparam int PW    = 15 - PAGE_WORD_BITS;
    localparam int WORDS = 1 << PAGE_WORD_BITS;

    ////////////////////////////////////////////////////////////////////////////
    // State
    fspc_pkg::fspc_ctrl_t      ctrl_ff,  nxt_ctrl;
    logic [15:0]               ptr_ff,   nxt_ptr;
    logic [7:0]                lock_ff,  nxt_lock;
    logic [2:0]                arm_ff,   nxt_arm;
    fspc_pkg::fspc_op_t        op_ff,    nxt_op;
    logic [31:0]               opcnt_ff, nxt_opcnt;
    logic [PW-1:0]             page_ff,  nxt_page;
    logic                      blk_ff,   nxt_blk;
    logic [15:0]               buf_mem [WORDS];
    logic [WORDS-1:0]          bvalid_ff;
    logic [31:0]               prdata_ff;
    logic                      pready_ff, pslverr_ff;
    logic [15:0]               vector_ff;
    logic                      irq_ff, halt_ff;
    logic [7:0]                ldata_ff;
    logic                      lvalid_ff, fread_ff;
    logic [15:0]               fraddr_ff;
    logic                      perase_ff, pwrite_ff, wvalid_ff;
    logic [PAGE_WORD_BITS-1:0] wword_ff;
    logic [15:0]               wdata_ff;

    ////////////////////////////////////////////////////////////////////////////
    // APB decode
    wire       apb_setup = psel & ~penable;
    wire       apb_wr    = psel & penable & pwrite;
    wire       hit_ctrl  = (paddr == fspc_pkg::OFS_CTRL_STATUS);
    wire       hit_ptrl  = (paddr == fspc_pkg::OFS_POINTER_LOW);
    wire       hit_ptrh  = (paddr == fspc_pkg::OFS_POINTER_HIGH);
    wire       hit_any   = hit_ctrl | hit_ptrl | hit_ptrh;
    wire       wr_ctrl   = apb_wr & hit_ctrl;
    wire [4:0] wr_cmd    = pwdata[4:0];
    wire       op_active = (op_ff != fspc_pkg::OP_IDLE);

    // Bit 5 always reads zero
    wire [7:0] ctrl_rd = {ctrl_ff.irq_en, ctrl_ff.busy, 1'b0, ctrl_ff[4:0]}; // [RULE3]
    wire [31:0] rd_mux = hit_ctrl ? {24'h000000, ctrl_rd} :
                         hit_ptrl ? {24'h000000, ptr_ff[7:0]} :
                         hit_ptrh ? {24'h000000, ptr_ff[15:8]} : 32'h00000000;

    // Legal pattern, no EEPROM write, no running operation
    wire cmd_legal = (wr_cmd == fspc_pkg::CMD_REENABLE) |
                     (wr_cmd == fspc_pkg::CMD_LOCK_SET) |
                     (wr_cmd == fspc_pkg::CMD_PG_WRITE) |
                     (wr_cmd == fspc_pkg::CMD_PG_ERASE) |
                     (wr_cmd == fspc_pkg::CMD_LOAD); // [RULE16]
    wire cmd_take  = wr_ctrl & cmd_legal & ~eeprom_write_active & ~op_active; // [RULE7] [RULE24]
    // Re-enable written while words sit in the buffer aborts the load
    wire buf_abort = cmd_take & (wr_cmd == fspc_pkg::CMD_REENABLE) & (|bvalid_ff); // [RULE8]

    ////////////////////////////////////////////////////////////////////////////
    // Arming windows and CPU request decode
    wire armed      = ctrl_ff.enable & ~op_active;
    wire store_open = armed & (arm_ff < fspc_pkg::STORE_WINDOW); // [RULE27]
    wire load_open  = armed & ctrl_ff.lock_set & (arm_ff < fspc_pkg::LOAD_WINDOW); // [RULE10]
    wire expire     = armed & (arm_ff == fspc_pkg::STORE_WINDOW - 3'h1); // [RULE27]
    wire st_go      = cpu_req.store & store_open & ~eeprom_write_active;
    wire st_load    = st_go & (ctrl_ff[4:0] == fspc_pkg::CMD_LOAD); // [RULE14]
    wire st_erase   = st_go & ctrl_ff.pg_erase; // [RULE12]
    wire st_write   = st_go & ctrl_ff.pg_write; // [RULE11]
    wire st_lock    = st_go & ctrl_ff.lock_set; // [RULE9]
    wire st_reen    = st_go & ctrl_ff.reenable; // [RULE7]
    wire ld_fuse    = cpu_req.load & load_open & ~eeprom_write_active; // [RULE24]
    wire ld_flash   = cpu_req.load & ~ld_fuse;

    // Word and page from pointer; byte bit ignored
    wire [PAGE_WORD_BITS-1:0] ptr_word = ptr_ff[PAGE_WORD_BITS:1]; // [RULE17] [RULE14]
    wire [PW-1:0]             ptr_page = ptr_ff[15:PAGE_WORD_BITS+1]; // [RULE17]
    wire                      ptr_blk  = (ptr_page >= BLOCK_FIRST_PAGE[PW-1:0]);
    wire                      op_start = st_erase | st_write;
    wire                      op_done  = op_active & (opcnt_ff == PROG_CYCLES - 1); // [RULE28]
    wire                      load_ok  = st_load & ~bvalid_ff[ptr_word]; // [RULE23] [RULE21]
    wire                      buf_clr  = buf_abort | st_reen |
                                         (op_done & (op_ff == fspc_pkg::OP_WRITE)); // [RULE23]

    // Fuse/lock source, zero = programmed
    wire [7:0] fuse_sel = (ptr_ff[1:0] == fspc_pkg::SEL_LOCK)      ? lock_ff   :
                          (ptr_ff[1:0] == fspc_pkg::SEL_FUSE_LOW)  ? fuse_low  :
                          (ptr_ff[1:0] == fspc_pkg::SEL_FUSE_HIGH) ? fuse_high :
                                                                     fuse_ext; // [RULE25] [RULE26]

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        nxt_ctrl  = ctrl_ff;
        nxt_ptr   = ptr_ff;
        nxt_lock  = lock_ff;
        nxt_arm   = arm_ff;
        nxt_op    = op_ff;
        nxt_opcnt = opcnt_ff;
        nxt_page  = page_ff;
        nxt_blk   = blk_ff;
        nxt_ctrl.reserved = 1'b0; // [RULE3]

        // Pointer registers
        if (apb_wr & hit_ptrl) begin
            nxt_ptr[7:0] = pwdata[7:0];
        end
        if (apb_wr & hit_ptrh) begin
            nxt_ptr[15:8] = pwdata[7:0];
        end

        // Window counter starts the cycle after the write
        if (armed & (arm_ff != fspc_pkg::STORE_WINDOW)) begin
            nxt_arm = arm_ff + 3'h1; // [RULE27]
        end

        // Command bits self-clear
        if (st_load | st_lock | st_reen | ld_fuse | (expire & ~op_start)) begin
            nxt_ctrl[4:0] = 5'h00; // [RULE15] [RULE9] [RULE27]
        end

        if (st_load) begin
            nxt_ctrl.busy = 1'b0; // [RULE6]
        end
        if (st_reen) begin
            nxt_ctrl.busy = 1'b0; // [RULE6] [RULE7]
        end
        if (st_lock) begin
            nxt_lock = lock_ff & (cpu_req.data_pair[7:0] | fspc_pkg::LOCK_KEEP_MASK); // [RULE9]
        end

        // Start erase/write
        if (op_start) begin
            nxt_op    = st_erase ? fspc_pkg::OP_ERASE : fspc_pkg::OP_WRITE;
            nxt_opcnt = 32'h00000000;
            nxt_page  = ptr_page; // [RULE18]
            nxt_blk   = ptr_blk;
            if (!ptr_blk) begin
                nxt_ctrl.busy = 1'b1; // [RULE5]
            end
        end else if (op_active) begin
            nxt_opcnt = opcnt_ff + 32'h00000001;
            if (op_done) begin
                nxt_op        = fspc_pkg::OP_IDLE;
                nxt_ctrl[4:0] = 5'h00; // [RULE15] [RULE11] [RULE12]
            end
        end

        // Software write wins over hardware
        if (wr_ctrl) begin
            nxt_ctrl.irq_en = pwdata[fspc_pkg::BIT_IRQ_EN];
            if (cmd_take) begin
                nxt_ctrl[4:0] = wr_cmd;
                nxt_arm       = 3'h0; // [RULE27]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff  <= fspc_pkg::CTRL_RESET; // [RULE3]
            ptr_ff   <= fspc_pkg::POINTER_RESET;
            lock_ff  <= fspc_pkg::LOCK_RESET;
            arm_ff   <= 3'h0;
            op_ff    <= fspc_pkg::OP_IDLE;
            opcnt_ff <= 32'h00000000;
            page_ff  <= '0;
            blk_ff   <= 1'b0;
        end else begin
            ctrl_ff  <= nxt_ctrl;
            ptr_ff   <= nxt_ptr;
            lock_ff  <= nxt_lock;
            arm_ff   <= nxt_arm;
            op_ff    <= nxt_op;
            opcnt_ff <= nxt_opcnt;
            page_ff  <= nxt_page;
            blk_ff   <= nxt_blk;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Temporary page buffer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bvalid_ff <= '0; // [RULE23]
        end else if (buf_clr) begin
            bvalid_ff <= '0; // [RULE8] [RULE23]
        end else if (load_ok) begin
            bvalid_ff[ptr_word] <= 1'b1; // [RULE21]
        end
    end

    always_ff @(posedge pclk) begin
        if (load_ok) begin
            buf_mem[ptr_word] <= cpu_req.data_pair; // [RULE14]
        end
    end

    // Page write streams buffer words first
    wire                      stream   = (op_ff == fspc_pkg::OP_WRITE) & (opcnt_ff < WORDS);
    wire [PAGE_WORD_BITS-1:0] stream_w = opcnt_ff[PAGE_WORD_BITS-1:0];
    wire [15:0]               stream_d = bvalid_ff[stream_w] ? buf_mem[stream_w] : 16'hFFFF;

    ////////////////////////////////////////////////////////////////////////////
    // APB answer and registered outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff  <= 32'h00000000;
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff <= 1'b1;
            if (apb_setup) begin
                prdata_ff  <= pwrite ? 32'h00000000 : rd_mux;
                pslverr_ff <= ~hit_any;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vector_ff <= fspc_pkg::APP_VECTOR;
            irq_ff    <= 1'b0;
            halt_ff   <= 1'b0;
            ldata_ff  <= 8'h00;
            lvalid_ff <= 1'b0;
            fread_ff  <= 1'b0;
            fraddr_ff <= 16'h0000;
            perase_ff <= 1'b0;
            pwrite_ff <= 1'b0;
            wvalid_ff <= 1'b0;
            wword_ff  <= '0;
            wdata_ff  <= 16'h0000;
        end else begin
            vector_ff <= boot_reset_select ? fspc_pkg::APP_VECTOR : BOOT_START; // [RULE1] [RULE2]
            irq_ff    <= ctrl_ff.irq_en & global_irq_enable & ~nxt_ctrl.enable; // [RULE4]
            halt_ff   <= (nxt_op != fspc_pkg::OP_IDLE) & nxt_blk; // [RULE13]
            lvalid_ff <= ld_fuse;
            if (ld_fuse) begin
                ldata_ff <= fuse_sel; // [RULE10] [RULE25]
            end
            fread_ff <= ld_flash;
            if (ld_flash) begin
                fraddr_ff <= ptr_ff; // [RULE19]
            end
            perase_ff <= st_erase;
            pwrite_ff <= st_write;
            wvalid_ff <= stream;
            wword_ff  <= stream_w;
            wdata_ff  <= stream_d;
        end
    end

    assign prdata          = prdata_ff;
    assign pready          = pready_ff;
    assign pslverr         = pslverr_ff;
    assign reset_vector    = vector_ff;
    assign ready_irq       = irq_ff;
    assign cpu_halt        = halt_ff;
    assign concurrent_busy = ctrl_ff.busy; // [RULE5]
    assign load_data       = ldata_ff;
    assign load_data_valid = lvalid_ff;
    assign flash_read      = fread_ff;
    assign flash_read_addr = fraddr_ff;
    assign prog_erase      = perase_ff;
    assign prog_write      = pwrite_ff;
    assign prog_page       = page_ff;
    assign prog_wvalid     = wvalid_ff;
    assign prog_wword      = wword_ff;
    assign prog_wdata      = wdata_ff;

endmodule : fspc_top

// File: test/fspc_props.sv
// Port checker for the flash self-program controller
`timescale 1ns/100ps

module fspc_props #(
    parameter logic [15:0] BOOT_START = 16'h1C00
) (
    input wire logic                    pclk,
    input wire logic                    presetn,
    input wire fspc_pkg::fspc_cpu_req_t cpu_req,
    input wire logic                    boot_reset_select,
    input wire logic [15:0]             reset_vector,
    input wire logic                    ready_irq,
    input wire logic                    cpu_halt,
    input wire logic                    concurrent_busy,
    input wire logic                    load_data_valid,
    input wire logic                    flash_read,
    input wire logic                    prog_erase,
    input wire logic                    prog_write,
    input wire logic                    prog_wvalid
);
    default clocking dc @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_vector_fuse: assert property (1'b1 |=>
        reset_vector == ($past(boot_reset_select) ? 16'h0000 : BOOT_START))
        else $error("vector wrong");
    a_prog_cause: assert property ((prog_erase || prog_write) |-> $past(cpu_req.store))
        else $error("no store");
    a_prog_single: assert property ((prog_erase || prog_write) |=> !(prog_erase || prog_write))
        else $error("pulse long");
    a_halt_start: assert property ($rose(cpu_halt) |-> (prog_erase || prog_write))
        else $error("halt cause");
    a_halt_whole: assert property ($rose(cpu_halt) |-> cpu_halt [*8])
        else $error("halt short");
    a_busy_start: assert property ($rose(concurrent_busy) |-> (prog_erase || prog_write))
        else $error("busy cause");
    a_busy_clear: assert property ($fell(concurrent_busy) |->
        ($past(cpu_req.store) || $past(cpu_req.store, 2)))
        else $error("busy clear");
    a_halt_irq: assert property ((cpu_halt && $past(cpu_halt)) |-> !ready_irq)
        else $error("irq in op");
    a_load_cause: assert property ((load_data_valid || flash_read) |-> $past(cpu_req.load))
        else $error("load cause");
    a_load_one: assert property (load_data_valid |-> !flash_read)
        else $error("two answers");
    a_write_stream: assert property (prog_write |-> ##[0:1] prog_wvalid)
        else $error("no stream");

    c_erase: cover property (prog_erase);
    c_write: cover property (prog_write);
    c_halt: cover property ($rose(cpu_halt));
    c_fuse: cover property (load_data_valid);
endmodule : fspc_props

bind fspc_top fspc_props #(.BOOT_START(BOOT_START)) i_props (
    .pclk(pclk), .presetn(presetn), .cpu_req(cpu_req),
    .boot_reset_select(boot_reset_select), .reset_vector(reset_vector),
    .ready_irq(ready_irq), .cpu_halt(cpu_halt), .concurrent_busy(concurrent_busy),
    .load_data_valid(load_data_valid), .flash_read(flash_read),
    .prog_erase(prog_erase), .prog_write(prog_write), .prog_wvalid(prog_wvalid)
);

// File: test/fspc_cpu_model.sv
// CPU core model issuing store and load program-memory instructions
`timescale 1ns/100ps

module fspc_cpu_model (
    input  wire logic             pclk,
    input  wire logic             cpu_halt,
    output fspc_pkg::fspc_cpu_req_t cpu_req,
    output logic                  global_irq_enable
);
    initial begin
        cpu_req = '0;
        global_irq_enable = 1'b0;
    end

    task automatic store(input logic [15:0] data);
        for (int i = 0; i < 1000 && cpu_halt === 1'b1; i++) @(posedge pclk);
        cpu_req.store <= 1'b1;
        cpu_req.data_pair <= data;
        @(posedge pclk);
        cpu_req.store <= 1'b0;
        cpu_req.data_pair <= ~data;
    endtask : store

    task automatic load();
        cpu_req.load <= 1'b1;
        @(posedge pclk);
        cpu_req.load <= 1'b0;
    endtask : load

    task automatic set_gie(input logic v);
        @(posedge pclk);
        global_irq_enable <= v;
    endtask : set_gie
endmodule : fspc_cpu_model

// File: test/fspc_top_test.sv
// Self-checking bench for the flash self-program controller
`timescale 1ns/100ps
`define CHK(got, exp) begin \
    checked++; \
    if ((got) !== (exp)) begin \
        num_errors++; \
        $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
    end \
end

module fspc_top_test;
    localparam logic [15:0] BOOT = 16'h1C00;
    localparam logic [11:0] CTRL = fspc_pkg::OFS_CTRL_STATUS;
    logic [7:0]              fexp [4] = '{8'h62, 8'hFF, 8'hF9, 8'hDF};
    logic                    pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic                    eeprom, boot_sel, gie, ready_irq, cpu_halt, busy;
    logic                    load_data_valid, flash_read, prog_erase, prog_write, prog_wvalid;
    logic [11:0]             paddr;
    logic [31:0]             pwdata, prdata, rd;
    logic [15:0]             reset_vector, flash_read_addr, prog_wdata;
    logic [7:0]              load_data;
    logic [9:0]              prog_page;
    logic [4:0]              prog_wword;
    logic [15:0]             wbuf [32];
    fspc_pkg::fspc_cpu_req_t cpu_req;
    int                      num_errors = 0;
    int                      checked = 0;

    fspc_top #(.PROG_CYCLES(40), .BOOT_START(BOOT)) i_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cpu_req(cpu_req), .global_irq_enable(gie), .eeprom_write_active(eeprom),
        .boot_reset_select(boot_sel), .fuse_low(fexp[0]), .fuse_high(fexp[3]),
        .fuse_ext(fexp[2]), .reset_vector(reset_vector), .ready_irq(ready_irq),
        .cpu_halt(cpu_halt), .concurrent_busy(busy), .load_data(load_data),
        .load_data_valid(load_data_valid), .flash_read(flash_read),
        .flash_read_addr(flash_read_addr), .prog_erase(prog_erase), .prog_write(prog_write),
        .prog_page(prog_page), .prog_wvalid(prog_wvalid), .prog_wword(prog_wword),
        .prog_wdata(prog_wdata)
    );
    fspc_cpu_model i_cpu (.pclk(pclk), .cpu_halt(cpu_halt), .cpu_req(cpu_req),
        .global_irq_enable(gie));

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end
    initial begin
        #5000000;
        num_errors++;
        wrap_up();
    end
    always @(posedge pclk) begin
        if (prog_wvalid === 1'b1) wbuf[prog_wword] <= prog_wdata;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        $display("checked=%0d num_errors=%0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : wrap_up

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            num_errors++;
            wrap_up();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wait_idle();
        for (int i = 0; i < 40; i++) begin
            apb(1'b0, CTRL, 32'h0);
            if (rd[0] === 1'b0) return;
        end
        num_errors++;
        wrap_up();
    endtask : wait_idle

    task automatic ptr(input logic [15:0] p);
        apb(1'b1, fspc_pkg::OFS_POINTER_LOW, {24'h0, p[7:0]});
        apb(1'b1, fspc_pkg::OFS_POINTER_HIGH, {24'h0, p[15:8]});
    endtask : ptr

    task automatic ld(input logic [15:0] p, input logic [15:0] d);
        ptr(p);
        apb(1'b1, CTRL, 32'h01);
        i_cpu.store(d);
    endtask : ld

    task automatic fuse_chk(input logic [1:0] sel, input logic [7:0] exp);
        ptr({14'h0, sel});
        apb(1'b1, CTRL, 32'h09);
        i_cpu.load();
        #1;
        `CHK(load_data_valid, 1'b1)
        `CHK(load_data, exp)
    endtask : fuse_chk

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, eeprom} = '0;
        boot_sel = 1'b1;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, CTRL, 32'h0);
        `CHK(rd, 32'h0)
        `CHK(reset_vector, 16'h0000)
        apb(1'b1, CTRL, 32'hBF);
        apb(1'b0, CTRL, 32'h0);
        `CHK(rd, 32'h80)
        apb(1'b0, 12'h00C, 32'h0);
        `CHK(err, 1'b1)
        apb(1'b1, CTRL, 32'h01);
        repeat (5) @(posedge pclk);
        apb(1'b0, CTRL, 32'h0);
        `CHK(rd, 32'h00)
        eeprom <= 1'b1;
        apb(1'b1, CTRL, 32'h03);
        apb(1'b0, CTRL, 32'h0);
        `CHK(rd, 32'h00)
        eeprom <= 1'b0;
        boot_sel <= 1'b0;
        repeat (2) @(posedge pclk);
        #1;
        `CHK(reset_vector, BOOT)
        for (int i = 0; i < 4; i++) fuse_chk(2'(i), fexp[i]);
        apb(1'b1, CTRL, 32'h09);
        i_cpu.store(16'hFF00);
        wait_idle();
        fuse_chk(2'h1, 8'hC3);
        ptr(16'h0047);
        i_cpu.load();
        #1;
        `CHK(flash_read_addr, 16'h0047)
        ld(16'h0047, 16'hA5A5);
        ld(16'h0040, 16'h1234);
        ptr(16'h0040);
        apb(1'b1, CTRL, 32'h03);
        i_cpu.store(16'h0);
        #1;
        `CHK(busy, 1'b1)
        `CHK(cpu_halt, 1'b0)
        ptr(16'hE000);
        apb(1'b1, CTRL, 32'h01);
        apb(1'b0, CTRL, 32'h0);
        `CHK(rd, 32'h43)
        `CHK(prog_page, 10'h001)
        wait_idle();
        ptr(16'h0040);
        apb(1'b1, CTRL, 32'h05);
        i_cpu.store(16'h0);
        wait_idle();
        `CHK(wbuf[3], 16'hA5A5)
        `CHK(wbuf[0], 16'h1234)
        `CHK(wbuf[1], 16'hFFFF)
        `CHK(prog_page, 10'h001)
        `CHK(busy, 1'b1)
        apb(1'b1, CTRL, 32'h11);
        i_cpu.store(16'h0);
        repeat (2) @(posedge pclk);
        #1;
        `CHK(busy, 1'b0)
        ptr(16'hE000);
        apb(1'b1, CTRL, 32'h03);
        i_cpu.store(16'h0);
        #1;
        `CHK(cpu_halt, 1'b1)
        `CHK(prog_page, 10'h380)
        wait_idle();
        `CHK(cpu_halt, 1'b0)
        ld(16'h004A, 16'h5555);
        apb(1'b1, CTRL, 32'h11);
        ptr(16'h0040);
        apb(1'b1, CTRL, 32'h05);
        i_cpu.store(16'h0);
        wait_idle();
        `CHK(wbuf[5], 16'hFFFF)
        `CHK(wbuf[3], 16'hFFFF)
        apb(1'b1, CTRL, 32'h80);
        i_cpu.set_gie(1'b1);
        repeat (2) @(posedge pclk);
        #1;
        `CHK(ready_irq, 1'b1)
        i_cpu.set_gie(1'b0);
        repeat (2) @(posedge pclk);
        #1;
        `CHK(ready_irq, 1'b0)
        wrap_up();
    end
endmodule : fspc_top_test
